//--- include/dcce_pkg.sv
// ****************************************
// constants for the complementary pair
// ****************************************
package dcce_pkg;
   // clock rate
   localparam int CLK_PERIOD_NS = 10;
   localparam int NS_PER_MS = 1000000;
   localparam int NS_PER_US = 1000;
   // cycles in one millisecond, timer prescale
   localparam int MS_CYCLES = NS_PER_MS / CLK_PERIOD_NS;
   // input filter time, printed in ms
   localparam int DEBOUNCE_TIME_MS = 3;
   localparam int DEBOUNCE_CYCLES = DEBOUNCE_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;
   // test pulse period and low width
   localparam int PULSE_PERIOD_MS = 10;
   localparam int PULSE_PERIOD_CYCLES = PULSE_PERIOD_MS * NS_PER_MS / CLK_PERIOD_NS;
   localparam int PULSE_WIDTH_US = 20;
   localparam int PULSE_WIDTH_CYCLES = PULSE_WIDTH_US * NS_PER_US / CLK_PERIOD_NS;
   // counter and period widths
   localparam int CNT_W = 20;
   localparam int DISC_W = 13;
   // positions of the synchronised pins
   localparam int IDX_CH_A = 0;
   localparam int IDX_CH_B = 1;
   localparam int IDX_FB_A = 2;
   localparam int IDX_FB_B = 3;
   localparam int PIN_N = 4;
   // values after reset
   localparam logic [3:0] PIN_RST = 4'h0;
   localparam logic [CNT_W-1:0] CNT_RST = 20'h00000;
   localparam logic [DISC_W-1:0] TMR_RST = 13'h0000;
   // evaluation states, gray along off-rise-on-fall
   typedef enum logic [1:0] {
      DCCE_OFF = 2'h0,
      DCCE_RISE = 2'h1,
      DCCE_ON = 2'h3,
      DCCE_FALL = 2'h2
   } dcce_state_t;
endpackage

//--- include/dcce_if.sv
`timescale 1ns/1ns
// ****************************************
// links between filter, pulse unit and top
// ****************************************
interface dcce_if;
   logic [3:0] raw_sync; // pins after two flops
   logic [3:0] level; // debounced pin levels
   logic out_a; // pulse output a level
   logic out_b; // pulse output b level
   logic smp_a; // inside low pulse of a
   logic smp_b; // inside low pulse of b
   logic short_a; // output a shorted to ground
   logic short_b; // output b shorted to ground
   logic ack; // acknowledge from control
   logic cross_en; // cross monitoring enabled
   modport filt (output raw_sync, output level);
   modport pulse (input raw_sync, input ack, input cross_en,
      output out_a, output out_b, output smp_a, output smp_b,
      output short_a, output short_b);
endinterface

//--- hdl/dcce_filt.sv
`timescale 1ns/1ns
// ****************************************
// pin synchroniser and debounce filter
// ****************************************
module dcce_filt #(
   parameter int DEB = dcce_pkg::DEBOUNCE_CYCLES
) (
   // system
   input wire logic clock,
   input wire logic rstn,
   // raw pins
   input wire logic [dcce_pkg::PIN_N-1:0] raw,
   // to consumers
   dcce_if.filt bus
);
   import dcce_pkg::*;

   // one synchroniser and filter per pin
   for (genvar i = 0; i < PIN_N; i++) begin : g_pin
      logic s1_q; // first stage, read only by s2_q
      logic s2_q; // second stage
      logic lvl_q, lvl_d; // accepted level
      logic [CNT_W-1:0] cnt_q, cnt_d; // stable time

      // level accepted after standing for the filter time
      always_comb begin
         lvl_d = lvl_q;
         cnt_d = CNT_RST;
         if (s2_q != lvl_q) begin
            if (cnt_q >= CNT_W'(DEB - 1)) begin
               lvl_d = s2_q;
            end else begin
               cnt_d = cnt_q + 1'b1;
            end
         end
      end

      // registers only
      always_ff @(posedge clock or negedge rstn) begin
         if (!rstn) begin
            s1_q <= PIN_RST[i];
            s2_q <= PIN_RST[i];
            lvl_q <= PIN_RST[i];
            cnt_q <= CNT_RST;
         end else begin
            s1_q <= raw[i];
            s2_q <= s1_q;
            lvl_q <= lvl_d;
            cnt_q <= cnt_d;
         end
      end

      assign bus.raw_sync[i] = s2_q;
      assign bus.level[i] = lvl_q;
   end
endmodule

//--- hdl/dcce_pulse.sv
`timescale 1ns/1ns
// ****************************************
// test pulse generator and short check
// ****************************************
module dcce_pulse #(
   parameter int PER = dcce_pkg::PULSE_PERIOD_CYCLES
) (
   // system
   input wire logic clock,
   input wire logic rstn,
   // to filter and top
   dcce_if.pulse bus
);
   import dcce_pkg::*;

   localparam int HALF = PER / 2;
   localparam int PW = PULSE_WIDTH_CYCLES;

   logic [CNT_W-1:0] per_q, per_d; // position in period
   logic out_a_q, out_a_d, out_b_q, out_b_d; // driven levels
   logic smp_a_q, smp_a_d, smp_b_q, smp_b_d; // sample points
   logic sh_a_q, sh_a_d, sh_b_q, sh_b_d; // sticky shorts
   logic chk_a, chk_b; // short check points

   // pulses a and b sit half a period apart, so either one
   // low while the other is high tells the wires apart
   always_comb begin
      per_d = (per_q >= CNT_W'(PER - 1)) ? CNT_RST : per_q + 1'b1;
      chk_a = per_q == CNT_W'(HALF - 1);
      chk_b = per_q == CNT_W'(PER - 1);
      // a high output reading back low is a short to ground
      sh_a_d = (chk_a && out_a_q && !bus.raw_sync[IDX_FB_A]) || (sh_a_q && !bus.ack);
      sh_b_d = (chk_b && out_b_q && !bus.raw_sync[IDX_FB_B]) || (sh_b_q && !bus.ack);
      // a shorted output is switched off
      out_a_d = !sh_a_q && !(bus.cross_en && per_q < CNT_W'(PW));
      out_b_d = !sh_b_q && !(bus.cross_en && per_q >= CNT_W'(HALF)
         && per_q < CNT_W'(HALF + PW));
      // sample at the end of the low, after sync delay
      smp_a_d = bus.cross_en && !sh_a_q && per_q == CNT_W'(PW - 1);
      smp_b_d = bus.cross_en && !sh_b_q && per_q == CNT_W'(HALF + PW - 1);
   end

   // registers only; outputs reset low, idle high after reset
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         per_q <= CNT_RST;
         out_a_q <= 1'b0;
         out_b_q <= 1'b0;
         smp_a_q <= 1'b0;
         smp_b_q <= 1'b0;
         sh_a_q <= 1'b0;
         sh_b_q <= 1'b0;
      end else begin
         per_q <= per_d;
         out_a_q <= out_a_d;
         out_b_q <= out_b_d;
         smp_a_q <= smp_a_d;
         smp_b_q <= smp_b_d;
         sh_a_q <= sh_a_d;
         sh_b_q <= sh_b_d;
      end
   end

   assign bus.out_a = out_a_q;
   assign bus.out_b = out_b_q;
   assign bus.smp_a = smp_a_q;
   assign bus.smp_b = smp_b_q;
   assign bus.short_a = sh_a_q;
   assign bus.short_b = sh_b_q;

   // shorted output stays off until acknowledged
   property p_short_off;
      @(posedge clock) disable iff (!rstn)
      (sh_a_q && !bus.ack) |=> (sh_a_q && !out_a_q);
   endproperty
   a_short_off: assert property (p_short_off) // RULE_13
      else $error("shorted output a not held off");
endmodule

//--- hdl/dcce_top.sv
`timescale 1ns/1ns
// ****************************************
// complementary input pair evaluation
// ****************************************

// How it works
// RULE_01 - off to on: a rises, b falls
// RULE_02 - pair incomplete within period raises discrepancy
// RULE_03 - active only while a high, b low
// RULE_04 - change from non-opposite levels gives discrepancy
// RULE_05 - image bit one only when all good
// RULE_06 - cross fault forces zero until acknowledged
// RULE_07 - acknowledge clears diagnostics, evaluation resumes live
// RULE_08 - discrepancy reported only with symmetry enabled
// RULE_09 - no inhibit: discrepancy leaves image live
// RULE_10 - inhibit: discrepancy forces zero until acknowledge
// RULE_11 - input to input short is cross fault
// RULE_12 - wrong pulse source seen as cross fault
// RULE_13 - pulse output short reported, output switched off
// RULE_14 - one-channel change caught as discrepancy
// RULE_15 - timer runs from first edge to partner
module dcce_top #(
   parameter int DEB_CYCLES = dcce_pkg::DEBOUNCE_CYCLES,
   parameter int MS_TICK = dcce_pkg::MS_CYCLES,
   parameter int PULSE_PER = dcce_pkg::PULSE_PERIOD_CYCLES
) (
   // system
   input wire logic clock,
   input wire logic rstn,
   // sensor contacts
   input wire logic input_channel_a,
   input wire logic input_channel_b,
   // test pulse outputs and their readback
   output logic test_pulse_out_a,
   output logic test_pulse_out_b,
   input wire logic test_pulse_fb_a,
   input wire logic test_pulse_fb_b,
   // configuration, steady from the control side
   input wire logic cfg_symmetry_en,
   input wire logic cfg_inhibit_en,
   input wire logic cfg_cross_en,
   input wire logic [dcce_pkg::DISC_W-1:0] cfg_disc_period_ms,
   // control system
   input wire logic ack,
   output logic process_bit,
   output logic diag_discrepancy,
   output logic diag_cross_fault,
   output logic diag_short_a,
   output logic diag_short_b
);
   import dcce_pkg::*;

   // ****************************************
   // sub units
   // ****************************************
   dcce_if bus ();

   assign bus.ack = ack;
   assign bus.cross_en = cfg_cross_en;

   // filter sees both contacts and both readbacks
   dcce_filt #(
      .DEB(DEB_CYCLES)
   ) u_filt (
      .clock(clock),
      .rstn(rstn),
      .raw({test_pulse_fb_b, test_pulse_fb_a, input_channel_b, input_channel_a}),
      .bus(bus)
   );

   dcce_pulse #(
      .PER(PULSE_PER)
   ) u_pulse (
      .clock(clock),
      .rstn(rstn),
      .bus(bus)
   );

   // ****************************************
   // declarations
   // ****************************************
   logic lvl_a, lvl_b; // debounced contact levels
   logic raw_a, raw_b; // synchronised, unfiltered
   logic pair_on; // a high, b low
   logic pair_off; // a low, b high
   dcce_state_t state_q, state_d; // evaluated state
   logic armed_q, armed_d; // last rest was opposite
   logic [CNT_W-1:0] pre_q, pre_d; // millisecond prescaler
   logic [DISC_W-1:0] tmr_q, tmr_d; // elapsed ms in change
   logic moving; // inside a change
   logic expire; // discrepancy period over
   logic disc_hit; // discrepancy event
   logic disc_q, disc_d; // sticky discrepancy
   logic cross_hit; // cross fault event
   logic cross_q, cross_d; // sticky cross fault
   logic pbit_q, pbit_d; // process image bit

   assign lvl_a = bus.level[IDX_CH_A];
   assign lvl_b = bus.level[IDX_CH_B];
   assign raw_a = bus.raw_sync[IDX_CH_A];
   assign raw_b = bus.raw_sync[IDX_CH_B];
   assign pair_on = lvl_a && !lvl_b; // RULE_03
   assign pair_off = !lvl_a && lvl_b;
   assign moving = state_q == DCCE_RISE || state_q == DCCE_FALL;
   assign expire = moving && tmr_q >= cfg_disc_period_ms;

   // ****************************************
   // discrepancy timer
   // ****************************************
   // counts whole ms from the first edge; stops and clears
   // as soon as the pair rests again
   always_comb begin
      pre_d = CNT_RST;
      tmr_d = TMR_RST;
      if (moving) begin // RULE_15
         pre_d = pre_q + 1'b1;
         tmr_d = tmr_q;
         if (pre_q >= CNT_W'(MS_TICK - 1)) begin
            pre_d = CNT_RST;
            // saturate rather than wrap into a false pass
            if (tmr_q != {DISC_W{1'b1}}) begin
               tmr_d = tmr_q + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pre_q <= CNT_RST;
         tmr_q <= TMR_RST;
      end else begin
         pre_q <= pre_d;
         tmr_q <= tmr_d;
      end
   end

   // ****************************************
   // pair state machine
   // ****************************************
   // disc_hit marks a change that did not follow the
   // complementary pattern; it is masked when symmetry
   // monitoring is off, and then the pair simply waits
   always_comb begin
      state_d = state_q;
      armed_d = armed_q;
      disc_hit = 1'b0;
      case (state_q)
         DCCE_OFF: begin
            if (pair_off) begin
               armed_d = 1'b1;
            end else if (pair_on) begin
               if (armed_q) begin
                  state_d = DCCE_ON; // RULE_01
               end else begin
                  disc_hit = 1'b1; // RULE_04
               end
            end else if (armed_q) begin
               // first edge of a rise
               state_d = DCCE_RISE;
            end
         end
         DCCE_RISE: begin
            if (pair_on) begin
               state_d = DCCE_ON; // RULE_01
            end else if (pair_off) begin
               state_d = DCCE_OFF;
            end else if (expire && cfg_symmetry_en) begin
               // only one channel moved
               disc_hit = 1'b1; // RULE_14
               state_d = DCCE_OFF;
               armed_d = 1'b0;
            end
         end
         DCCE_ON: begin
            if (pair_off) begin
               state_d = DCCE_OFF;
               armed_d = 1'b1;
            end else if (!pair_on) begin
               state_d = DCCE_FALL;
            end
         end
         DCCE_FALL: begin
            if (pair_off) begin
               state_d = DCCE_OFF;
               armed_d = 1'b1;
            end else if (pair_on) begin
               state_d = DCCE_ON;
            end else if (expire && cfg_symmetry_en) begin
               disc_hit = 1'b1; // RULE_02
               state_d = DCCE_OFF;
               armed_d = 1'b0;
            end
         end
         default: begin
            state_d = DCCE_OFF;
            armed_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_q <= DCCE_OFF;
         armed_q <= 1'b0;
      end else begin
         state_q <= state_d;
         armed_q <= armed_d;
      end
   end

   // ****************************************
   // diagnostics and process image
   // ****************************************
   // cross check: during its own low pulse a high input must
   // drop; an input on the other pulse must not drop
   always_comb begin
      cross_hit = cfg_cross_en && (
         (bus.smp_a && ((lvl_a && raw_a) || (lvl_b && !raw_b))) ||
         (bus.smp_b && ((lvl_b && raw_b) || (lvl_a && !raw_a)))); // RULE_11 RULE_12
      // a new event wins over acknowledge in the same cycle
      disc_d = (disc_hit && cfg_symmetry_en) || (disc_q && !ack); // RULE_08
      cross_d = cross_hit || (cross_q && !ack); // RULE_07
      // live state unless a fault holds the safe state
      pbit_d = state_q == DCCE_ON && pair_on && !cross_q
         && !(disc_q && cfg_inhibit_en); // RULE_05 RULE_06 RULE_09 RULE_10
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         disc_q <= 1'b0;
         cross_q <= 1'b0;
         pbit_q <= 1'b0;
      end else begin
         disc_q <= disc_d;
         cross_q <= cross_d;
         pbit_q <= pbit_d;
      end
   end

   assign process_bit = pbit_q;
   assign diag_discrepancy = disc_q;
   assign diag_cross_fault = cross_q;
   assign diag_short_a = bus.short_a; // RULE_13
   assign diag_short_b = bus.short_b;
   assign test_pulse_out_a = bus.out_a;
   assign test_pulse_out_b = bus.out_b;

   // ****************************************
   // checks
   // ****************************************
   property p_rise_pattern;
      @(posedge clock) disable iff (!rstn)
      (state_q == DCCE_ON && $past(state_q) == DCCE_OFF) |-> $past(armed_q);
   endproperty
   a_rise_pattern: assert property (p_rise_pattern) // RULE_01
      else $error("pair switched on without opposite rest");

   property p_active_levels;
      @(posedge clock) disable iff (!rstn)
      process_bit |-> $past(lvl_a) && !$past(lvl_b);
   endproperty
   a_active_levels: assert property (p_active_levels) // RULE_03
      else $error("image bit set without a high and b low");

   // the image register lags the sticky flag by one cycle, so the
   // safe state is due one cycle after diag_cross_fault rises
   property p_cross_safe;
      @(posedge clock) disable iff (!rstn)
      cross_q |=> !process_bit;
   endproperty
   a_cross_safe: assert property (p_cross_safe) // RULE_06
      else $error("cross fault did not force safe state");

   property p_cross_detect;
      @(posedge clock) disable iff (!rstn)
      (cfg_cross_en && bus.smp_a && lvl_b && !raw_b) |=> cross_q;
   endproperty
   a_cross_detect: assert property (p_cross_detect) // RULE_11
      else $error("input short under pulse a not flagged");

   property p_ack_clear;
      @(posedge clock) disable iff (!rstn)
      (ack && !disc_hit && !cross_hit) |=> !disc_q && !cross_q;
   endproperty
   a_ack_clear: assert property (p_ack_clear) // RULE_07
      else $error("acknowledge did not clear diagnostics");

   property p_disc_masked;
      @(posedge clock) disable iff (!rstn)
      $rose(disc_q) |-> $past(cfg_symmetry_en);
   endproperty
   a_disc_masked: assert property (p_disc_masked) // RULE_08
      else $error("discrepancy reported with symmetry off");

   property p_live_no_inhibit;
      @(posedge clock) disable iff (!rstn)
      (disc_q && !cfg_inhibit_en && !cross_q && state_q == DCCE_ON && pair_on)
         |=> process_bit;
   endproperty
   a_live_no_inhibit: assert property (p_live_no_inhibit) // RULE_09
      else $error("discrepancy without inhibit blocked image");

   property p_inhibit_safe;
      @(posedge clock) disable iff (!rstn)
      (disc_q && cfg_inhibit_en) |=> !process_bit;
   endproperty
   a_inhibit_safe: assert property (p_inhibit_safe) // RULE_10
      else $error("inhibit did not force safe state");

   property p_timeout;
      @(posedge clock) disable iff (!rstn)
      (moving && expire && cfg_symmetry_en && !pair_on && !pair_off)
         |=> disc_q && state_q == DCCE_OFF;
   endproperty
   a_timeout: assert property (p_timeout) // RULE_02
      else $error("discrepancy period expiry not flagged");

   property p_timer_rest;
      @(posedge clock) disable iff (!rstn)
      !moving |=> tmr_q == TMR_RST && pre_q == CNT_RST;
   endproperty
   a_timer_rest: assert property (p_timer_rest) // RULE_15
      else $error("discrepancy timer not cleared at rest");
endmodule

//--- verif/dcce_sensor_model.sv
`timescale 1ns/1ns
// ************************************
// contacts and wiring of the input pair
// ************************************
module dcce_sensor_model (
   // pulse outputs of the device
   input wire logic test_pulse_out_a,
   input wire logic test_pulse_out_b,
   // contact positions, wiring fault code
   input wire logic close_a,
   input wire logic close_b,
   input wire logic [2:0] fault,
   // pins toward the device
   output logic input_channel_a,
   output logic input_channel_b,
   output logic test_pulse_fb_a,
   output logic test_pulse_fb_b
);
   logic wire_a; // contact a output, pulled down when open
   logic wire_b; // contact b output, pulled down when open
   // open contacts read low; faults replace the source or short the lines
   always_comb begin
      wire_a = close_a & ((fault == 3'h1) ? test_pulse_out_b : test_pulse_out_a);
      wire_b = close_b & test_pulse_out_b;
      input_channel_a = (fault == 3'h3) ? (wire_a | wire_b) : wire_a;
      input_channel_b = (fault == 3'h3) ? (wire_a | wire_b) : wire_b;
      test_pulse_fb_a = (fault == 3'h2) ? 1'b0 : test_pulse_out_a;
      test_pulse_fb_b = (fault == 3'h4) ? 1'b0 : test_pulse_out_b;
   end
endmodule

//--- verif/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   import dcce_pkg::*;
   // ************************************
   // shortened counts
   // ************************************
   localparam int DEB = 2100; // longer than the 2000-cycle pulse so it never passes
   localparam int TICK = 10; // ms tick, so 2 ms is 20 cycles
   localparam int PER = 4200; // just above twice the pulse width
   logic clock, rstn, ack, sym_en, inh_en, cross_en, close_a, close_b;
   logic [DISC_W-1:0] disc_ms; // discrepancy period
   logic [2:0] fault; // injected wiring fault
   logic ch_a, ch_b, out_a, out_b, fb_a, fb_b;
   logic pbit, d_disc, d_cross, d_sa, d_sb;
   logic [4:0] obs; // observed outputs, indexed by wait_bit
   int miscompares, n_tests;
   int m;
   assign obs = {d_sb, d_sa, d_cross, d_disc, pbit};
   dcce_top #(.DEB_CYCLES(DEB), .MS_TICK(TICK), .PULSE_PER(PER)) DUT (
      .clock(clock), .rstn(rstn), .input_channel_a(ch_a), .input_channel_b(ch_b),
      .test_pulse_out_a(out_a), .test_pulse_out_b(out_b),
      .test_pulse_fb_a(fb_a), .test_pulse_fb_b(fb_b),
      .cfg_symmetry_en(sym_en), .cfg_inhibit_en(inh_en), .cfg_cross_en(cross_en),
      .cfg_disc_period_ms(disc_ms), .ack(ack), .process_bit(pbit),
      .diag_discrepancy(d_disc), .diag_cross_fault(d_cross),
      .diag_short_a(d_sa), .diag_short_b(d_sb));
   dcce_sensor_model sensor (
      .test_pulse_out_a(out_a), .test_pulse_out_b(out_b), .close_a(close_a),
      .close_b(close_b), .fault(fault), .input_channel_a(ch_a),
      .input_channel_b(ch_b), .test_pulse_fb_a(fb_a), .test_pulse_fb_b(fb_b));
   // free running 100 MHz clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // ************************************
   // helpers
   // ************************************
   task automatic report_and_stop;
      $display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
      if (miscompares == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk1(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // drives land 1 ns after the edge
   task automatic idle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // bounded wait; running out counts as a mismatch and ends the run
   task automatic wait_bit(input int idx, input logic val, input int lim);
      for (int i = 0; i < lim; i++) begin
         if (obs[idx] === val) begin
            return;
         end
         idle(1);
      end
      chk1(obs[idx], val);
      report_and_stop();
   endtask
   task automatic pins(input logic a, input logic b);
      close_a = a;
      close_b = b;
   endtask
   // one-cycle acknowledge
   task automatic pulse_ack;
      ack = 1'b1;
      idle(1);
      ack = 1'b0;
   endtask
   // back to off rest and acknowledge, which arms the pair again
   task automatic rest_ack;
      pins(1'b0, 1'b1);
      idle(DEB + 10);
      pulse_ack();
      idle(3);
   endtask
   // ************************************
   // sequence
   // ************************************
   initial begin
      rstn = 1'b0;
      ack = 1'b0;
      sym_en = 1'b1;
      inh_en = 1'b0;
      cross_en = 1'b0;
      disc_ms = 13'h0002;
      fault = 3'h0;
      miscompares = 0;
      n_tests = 0;
      pins(1'b0, 1'b0);
      idle(5);
      chk1(pbit, 1'b0);
      chk1(out_a | out_b, 1'b0);
      rstn = 1'b1;
      // on pattern without prior rest is refused
      pins(1'b1, 1'b0);
      wait_bit(1, 1'b1, DEB + 80);
      chk1(pbit, 1'b0);
      rest_ack();
      chk1(d_disc, 1'b0);
      // clean complementary change both ways
      pins(1'b1, 1'b0);
      wait_bit(0, 1'b1, DEB + 10);
      chk1(d_disc, 1'b0);
      pins(1'b0, 1'b1);
      wait_bit(0, 1'b0, DEB + 10);
      // contact b fails to open: timer runs from a's edge
      pins(1'b1, 1'b1);
      idle(DEB + 5);
      chk1(d_disc, 1'b0);
      wait_bit(1, 1'b1, 60);
      chk1(pbit, 1'b0);
      // inhibit off then on: image live or forced to zero
      for (m = 0; m < 2; m++) begin
         inh_en = m[0];
         rest_ack();
         pins(1'b1, 1'b1);
         wait_bit(1, 1'b1, DEB + 80);
         pins(1'b0, 1'b1);
         idle(DEB + 10);
         pins(1'b1, 1'b0);
         idle(DEB + 10);
         chk1(pbit, ~m[0]);
         chk1(d_disc, 1'b1);
         pulse_ack();
         idle(3);
         chk1(pbit, 1'b1);
         chk1(d_disc, 1'b0);
      end
      // symmetry off: one-channel change stays silent
      sym_en = 1'b0;
      rest_ack();
      pins(1'b1, 1'b1);
      idle(DEB + 100);
      chk1(d_disc, 1'b0);
      chk1(pbit, 1'b0);
      // cross faults: wrong pulse source, then inputs shorted together
      cross_en = 1'b1;
      for (m = 1; m < 4; m += 2) begin
         rest_ack();
         pins(1'b1, 1'b0);
         // pulsed a needs a whole high stretch to pass the filter, and a
         // contact moving near a sample point may raise a cross fault,
         // so let both levels settle and clear it before looking
         idle(PER + DEB + 10);
         pulse_ack();
         wait_bit(0, 1'b1, 10);
         fault = m[2:0];
         wait_bit(2, 1'b1, 2 * PER + DEB);
         idle(2);
         chk1(pbit, 1'b0);
         fault = 3'h0;
         idle(DEB + 10);
         chk1(pbit, 1'b0);
         pulse_ack();
         idle(3);
         chk1(d_cross, 1'b0);
         chk1(pbit, 1'b1);
      end
      // pulse outputs shorted to ground, a then b
      cross_en = 1'b0;
      for (m = 0; m < 2; m++) begin
         fault = m[0] ? 3'h4 : 3'h2;
         wait_bit(3 + m, 1'b1, PER + 10);
         idle(3);
         chk1(m[0] ? out_b : out_a, 1'b0);
         fault = 3'h0;
         pulse_ack();
         idle(2);
         chk1(m[0] ? out_b : out_a, 1'b1);
         chk1(m[0] ? d_sb : d_sa, 1'b0);
      end
      report_and_stop();
   end
endmodule
